// ### core/core_seq.sv
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/10ps
module core_seq (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Sequencer operations
  input wire logic [2:0] pc_op_i,
  input wire logic [10:0] operand_i,
  // Data space port
  output logic [8:0] data_addr_o,
  output logic data_rd_o,
  output logic data_wr_o,
  output logic [7:0] data_wdata_o,
  input wire logic [7:0] data_rdata_i,
  // Timer and interrupt pins
  input wire logic timer_ext_clock_pin_i,
  input wire logic ext_irq_pin_i,
  input wire logic [7:0] pin_pullup_enable_i,
  // Derived controls
  output logic [7:0] pullup_active_o,
  output logic ext_irq_edge_o,
  output logic timer_tick_o,
  output logic wdt_tick_o,
  input wire logic wdt_base_tick_i,
  output logic [12:0] pc_o
);
  // ***********************
  // State
  // ***********************
  logic [7:0] option_q;
  logic [12:0] pc_q;
  logic [12:0] pc_d;
  logic [4:0] latch_q;
  logic [7:0] pointer_q;
  logic [7:0] status_q;
  logic [7:0] presc_q;
  logic ack_q;
  ret_stack_if stk ();

  ret_stack u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .st(stk)
  );

  // ***********************
  // Wishbone decode
  // ***********************
  logic req;
  logic wr_req;
  logic [3:0] widx;
  assign req = cyc_i && stb_i && !ack_q;
  assign wr_req = req && we_i && sel_i[0];
  assign widx = adr_i[5:2];
  assign ack_o = ack_q;

  // One write strobe per register, so each process owns one concern
  logic opt_wr;
  logic latch_wr;
  logic ptr_wr;
  logic status_wr;
  logic ind_wr;
  assign opt_wr = wr_req && widx == core_seq_pkg::ADDR_OPTION;
  assign latch_wr = wr_req && widx == core_seq_pkg::ADDR_PC_HIGH_LATCH;
  assign ptr_wr = wr_req && widx == core_seq_pkg::ADDR_IND_POINTER;
  assign status_wr = wr_req && widx == core_seq_pkg::ADDR_STATUS;
  assign ind_wr = wr_req && widx == core_seq_pkg::ADDR_IND_PORT;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // ***********************
  // Option register
  // ***********************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_q <= core_seq_pkg::OPTION_RST;
    end else if (opt_wr) begin
      option_q <= dat_i[7:0];
    end
  end

  logic pullup_global_disable;
  logic ext_irq_edge_sel;
  logic timer_clk_src_sel;
  logic timer_ext_edge_sel;
  logic prescaler_owner_sel;
  logic [2:0] prescale_rate_code;
  assign pullup_global_disable = option_q[core_seq_pkg::OPT_PULLUP_BIT];
  assign ext_irq_edge_sel = option_q[core_seq_pkg::OPT_INTEDGE_BIT];
  assign timer_clk_src_sel = option_q[core_seq_pkg::OPT_CLKSRC_BIT];
  assign timer_ext_edge_sel = option_q[core_seq_pkg::OPT_SRCEDGE_BIT];
  assign prescaler_owner_sel = option_q[core_seq_pkg::OPT_OWNER_BIT];
  assign prescale_rate_code = option_q[2:0];

  // Pull-up needs the global enable and its own pin bit
  assign pullup_active_o = pullup_global_disable ? 8'h00 : pin_pullup_enable_i;

  // ***********************
  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
  // ***********************
  // Slot 0 is the timer clock pin, slot 1 the interrupt pin
  logic [1:0] pin_raw;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;
  assign pin_raw = {ext_irq_pin_i, timer_ext_clock_pin_i};

  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic [2:0] sync_q;
    logic lvl_q;
    logic agree;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync_q <= 3'h0;
      end else begin
        sync_q <= {sync_q[1:0], pin_raw[g]};
      end
    end

    // Two matching samples are needed, so a one-cycle glitch is dropped
    assign agree = sync_q[1] == sync_q[2];

    // Level resets low: a pin held high through reset shows one rise
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lvl_q <= 1'b0;
      end else if (agree) begin
        lvl_q <= sync_q[2];
      end
    end

    assign pin_rise[g] = agree && sync_q[2] && !lvl_q;
    assign pin_fall[g] = agree && !sync_q[2] && lvl_q;
  end

  logic t_rise;
  logic t_fall;
  logic i_rise;
  logic i_fall;
  assign t_rise = pin_rise[0];
  assign t_fall = pin_fall[0];
  assign i_rise = pin_rise[1];
  assign i_fall = pin_fall[1];

  // Edge detector output is a combinational pulse off registered levels
  assign ext_irq_edge_o = ext_irq_edge_sel ? i_rise : i_fall;

  // ***********************
  // Shared prescaler
  // ***********************
  logic src_tick;
  logic presc_in;
  logic presc_out;
  logic [7:0] presc_mask;
  logic [2:0] shift_n;
  // Internal source ticks every instruction clock
  assign src_tick = timer_clk_src_sel ? (timer_ext_edge_sel ? t_fall : t_rise) : 1'b1;
  assign presc_in = prescaler_owner_sel ? wdt_base_tick_i : src_tick;
  assign shift_n = prescaler_owner_sel ? prescale_rate_code : prescale_rate_code + 3'h1;
  // Mask of 2^n - 1 (timer adds one more stage); code 7 for timer is 1:256
  assign presc_mask = (prescaler_owner_sel || prescale_rate_code != 3'h7) ?
                      8'((9'h001 << shift_n) - 9'h001) : 8'hff;
  assign presc_out = presc_in && ((presc_q & presc_mask) == presc_mask);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= 8'h00;
    end else if (presc_in) begin
      presc_q <= presc_out ? 8'h00 : presc_q + 8'h01;
    end
  end

  // Non-owner sees its source undivided
  assign timer_tick_o = prescaler_owner_sel ? src_tick : presc_out;
  assign wdt_tick_o = prescaler_owner_sel ? presc_out : wdt_base_tick_i;

  // ***********************
  // Status bank bit and indirect pointer
  // ***********************
  logic [8:0] ind_addr;
  logic ind_self;
  assign ind_addr = {status_q[core_seq_pkg::STATUS_BANK_BIT], pointer_q};
  assign ind_self = ind_addr[6:0] == core_seq_pkg::IND_PORT_LOC;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pointer_q <= core_seq_pkg::POINTER_RST;
    end else if (ptr_wr) begin
      pointer_q <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= core_seq_pkg::STATUS_RST;
    end else if (status_wr) begin
      status_q <= dat_i[7:0];
    end
  end

  // Access to the port goes to the pointed location instead
  assign data_addr_o = ind_addr;
  assign data_rd_o = req && !we_i && widx == core_seq_pkg::ADDR_IND_PORT && !ind_self;
  // Self-pointing write never reaches the data space
  assign data_wr_o = ind_wr && !ind_self;
  assign data_wdata_o = dat_i[7:0];

  // ***********************
  // High latch and program counter
  // ***********************
  // Latch is only touched by software writes, never by stack traffic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_q <= core_seq_pkg::LATCH_RST;
    end else if (latch_wr) begin
      latch_q <= dat_i[4:0];
    end
  end

  logic pcl_wr;
  logic do_push;
  logic do_pop;
  assign pcl_wr = wr_req && widx == core_seq_pkg::ADDR_PC_LOW;
  // Bus write to the low byte takes priority over the sequencer
  assign do_push = !pcl_wr && (pc_op_i == core_seq_pkg::PC_CALL ||
                               pc_op_i == core_seq_pkg::PC_IRQ);
  // Popping an empty stack returns a stale entry; nothing flags it
  assign do_pop = !pcl_wr && pc_op_i == core_seq_pkg::PC_RET;

  always_comb begin
    pc_d = pc_q;
    if (pcl_wr) begin
      pc_d = {latch_q, dat_i[7:0]};
    end else begin
      case (pc_op_i)
        core_seq_pkg::PC_STEP: pc_d = pc_q + 13'h0001;
        core_seq_pkg::PC_CALL, core_seq_pkg::PC_JUMP: pc_d = {latch_q[4:3], operand_i};
        core_seq_pkg::PC_RET: pc_d = stk.top_data;
        core_seq_pkg::PC_IRQ: pc_d = core_seq_pkg::IRQ_VECTOR;
        default: pc_d = pc_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_q <= core_seq_pkg::PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Push the address to resume at: next for call, current for interrupt
  assign stk.push = do_push;
  assign stk.pop = do_pop;
  assign stk.push_data = (pc_op_i == core_seq_pkg::PC_CALL) ? pc_q + 13'h0001 : pc_q;
  assign pc_o = pc_q;

  // ***********************
  // Read mux
  // ***********************
  logic [7:0] rd_byte;
  always_comb begin
    case (widx)
      core_seq_pkg::ADDR_OPTION: rd_byte = option_q;
      core_seq_pkg::ADDR_PC_LOW: rd_byte = pc_q[7:0];
      core_seq_pkg::ADDR_PC_HIGH_LATCH: rd_byte = {3'h0, latch_q};
      core_seq_pkg::ADDR_IND_POINTER: rd_byte = pointer_q;
      core_seq_pkg::ADDR_STATUS: rd_byte = status_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      if (widx == core_seq_pkg::ADDR_PC_FULL) begin
        dat_o <= {19'h0, pc_q};
      end else if (widx == core_seq_pkg::ADDR_IND_PORT) begin
        dat_o <= {24'h0, ind_self ? 8'h00 : data_rdata_i};
      end else begin
        dat_o <= {24'h0, rd_byte};
      end
    end
  end
endmodule

// ### core/core_seq_pkg.sv
package core_seq_pkg;
  // ***********************
  // Register map (word offsets on the bus)
  // ***********************
  localparam logic [3:0] ADDR_OPTION = 4'h0;
  localparam logic [3:0] ADDR_PC_LOW = 4'h1;
  localparam logic [3:0] ADDR_PC_HIGH_LATCH = 4'h2;
  localparam logic [3:0] ADDR_IND_POINTER = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PC_FULL = 4'h5;
  localparam logic [3:0] ADDR_IND_PORT = 4'h6;
  // ***********************
  // Field positions and widths
  // ***********************
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int DADDR_W = 9;
  localparam int OPT_PULLUP_BIT = 7;
  localparam int OPT_INTEDGE_BIT = 6;
  localparam int OPT_CLKSRC_BIT = 5;
  localparam int OPT_SRCEDGE_BIT = 4;
  localparam int OPT_OWNER_BIT = 3;
  localparam int STATUS_BANK_BIT = 7;
  // Indirect port location in the data space (low 7 bits in every bank)
  localparam logic [6:0] IND_PORT_LOC = 7'h00;
  // ***********************
  // Reset values
  // ***********************
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [4:0] LATCH_RST = 5'h00;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Program-counter operations from the sequencer
  typedef enum logic [2:0] {
    PC_HOLD = 3'b000,
    PC_STEP = 3'b001,
    PC_CALL = 3'b011,
    PC_JUMP = 3'b010,
    PC_RET = 3'b110,
    PC_IRQ = 3'b111
  } pc_op_e;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
endpackage

// ### core/ret_stack_if.sv
`timescale 1ns/10ps
interface ret_stack_if;
  logic push;
  logic pop;
  logic [12:0] push_data;
  logic [12:0] top_data;
  modport owner (output push, output pop, output push_data, input top_data);
  modport store (input push, input pop, input push_data, output top_data);
endinterface

// ### core/ret_stack.sv
`timescale 1ns/10ps
module ret_stack (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Stack port
  ret_stack_if.store st
);
  logic [12:0] mem_q [core_seq_pkg::STACK_DEPTH];
  logic [2:0] sp_q;
  logic [2:0] sp_dec;

  assign sp_dec = sp_q - 3'h1;
  // Top of stack is the entry below the pointer
  assign st.top_data = mem_q[sp_dec];

  // ***********************
  // Circular pointer, never visible to software
  // ***********************
  // Wraps freely; no overflow or underflow status is kept.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_q <= 3'h0;
    end else if (st.push) begin
      sp_q <= sp_q + 3'h1;
    end else if (st.pop) begin
      sp_q <= sp_dec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (st.push) begin
      mem_q[sp_q] <= st.push_data;
    end
  end
endmodule

// ### tb/core_seq_checker.sv
`timescale 1ns/10ps
module core_seq_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and sequencer
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [2:0] pc_op_i,
  input wire logic [10:0] operand_i,
  // Outputs watched
  input wire logic [8:0] data_addr_o,
  input wire logic data_wr_o,
  input wire logic data_rd_o,
  input wire logic [7:0] data_wdata_o,
  input wire logic [7:0] pin_pullup_enable_i,
  input wire logic [7:0] pullup_active_o,
  input wire logic [12:0] pc_o
);
  logic req;
  logic pcl_wr;
  assign req = cyc_i & stb_i & ~ack_o;
  // A low-byte write wins over any sequencer op in the same cycle
  assign pcl_wr = req & we_i & sel_i[0] & (adr_i[5:2] == 4'h1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK: assert property (req |=> ack_o)
    else $error("request not acked");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_PC_RESET: assert property (disable iff (1'b0) rst_i |=> pc_o == 13'h0000)
    else $error("pc not cleared by reset");
  AST_STEP: assert property (pc_op_i == 3'h1 && !pcl_wr |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("pc step wrong");
  AST_BRANCH: assert property (pc_op_i[2:1] == 2'b01 && !pcl_wr |=> pc_o[10:0] == $past(operand_i))
    else $error("branch target wrong");
  AST_IRQ: assert property (pc_op_i == 3'h7 && !pcl_wr |=> pc_o == 13'h0004)
    else $error("irq vector wrong");
  AST_PCL: assert property (pcl_wr |=> pc_o[7:0] == $past(dat_i[7:0]))
    else $error("low byte write lost");
  AST_IND_WR: assert property (data_wr_o |-> data_addr_o[6:0] != 7'h00 && data_wdata_o == dat_i[7:0])
    else $error("indirect write wrong");
  AST_IND_RD: assert property (data_rd_o |-> data_addr_o[6:0] != 7'h00)
    else $error("indirect read of the port itself");
  AST_PULLUP: assert property ((pullup_active_o & ~pin_pullup_enable_i) == 8'h00)
    else $error("pull-up without pin enable");
  cover property (pcl_wr);
  cover property (pc_op_i == 3'h7);
  cover property (data_wr_o);
  cover property (pc_op_i == 3'h6);
endmodule

bind core_seq core_seq_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .pc_op_i(pc_op_i), .operand_i(operand_i), .data_addr_o(data_addr_o),
  .data_wr_o(data_wr_o), .data_rd_o(data_rd_o), .data_wdata_o(data_wdata_o),
  .pin_pullup_enable_i(pin_pullup_enable_i), .pullup_active_o(pullup_active_o), .pc_o(pc_o));

// ### tb/core_seq_tb.sv
`timescale 1ns/10ps
module core_seq_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, tpin = 1'b0, ipin = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic [2:0] pc_op_i = 3'h0;
  logic [10:0] operand_i = 11'h000;
  logic [8:0] data_addr_o;
  logic data_rd_o, data_wr_o, ext_irq_edge_o, timer_tick_o, wdt_tick_o, wr_q = 1'b0;
  logic [7:0] data_wdata_o, pullup_active_o;
  logic [7:0] data_rdata_i = 8'h3c;
  logic [7:0] pen = 8'ha5;
  logic wdt_base_tick_i = 1'b0;
  logic [12:0] pc_o, epc;
  logic [12:0] st [8];
  logic [2:0] sp;
  int n_errors = 0, comparisons = 0, n_tt = 0, n_wt = 0, n_ei = 0, n_dw = 0, n_dr = 0, b0, b1;

  core_seq dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pc_op_i(pc_op_i), .operand_i(operand_i), .data_addr_o(data_addr_o),
    .data_rd_o(data_rd_o), .data_wr_o(data_wr_o), .data_wdata_o(data_wdata_o),
    .data_rdata_i(data_rdata_i), .timer_ext_clock_pin_i(tpin), .ext_irq_pin_i(ipin),
    .pin_pullup_enable_i(pen), .pullup_active_o(pullup_active_o),
    .ext_irq_edge_o(ext_irq_edge_o), .timer_tick_o(timer_tick_o), .wdt_tick_o(wdt_tick_o),
    .wdt_base_tick_i(wdt_base_tick_i), .pc_o(pc_o));

  initial forever #20 clk_i = ~clk_i;

  // Counters move by NBA so snapshots taken at an edge never race them
  always @(posedge clk_i) begin
    wdt_base_tick_i <= ~wdt_base_tick_i;
    wr_q <= data_wr_o;
    n_tt <= n_tt + int'(timer_tick_o === 1'b1);
    n_wt <= n_wt + int'(wdt_tick_o === 1'b1);
    n_ei <= n_ei + int'(ext_irq_edge_o === 1'b1);
    n_dw <= n_dw + int'(data_wr_o === 1'b1 && wr_q !== 1'b1);
    n_dr <= n_dr + int'(data_rd_o === 1'b1);
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    // Taken at the first edge, ack seen high at the second
    chk(n, 32'd2);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic op(input logic [2:0] o, input logic [10:0] a);
    @(posedge clk_i);
    pc_op_i <= o;
    operand_i <= a;
    @(posedge clk_i);
    pc_op_i <= 3'h0;
    #1;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h0, 1'b0, 8'h00);
    chk(rdat, 32'hff);
    chk(pc_o, 13'h0000);
    chk(pullup_active_o, 8'h00);
    wb(4'h0, 1'b1, 8'h7f);
    wb(4'h0, 1'b0, 8'h00);
    chk(rdat, 32'h7f);
    chk(pullup_active_o, 8'ha5);
    $display("test option done");
    wb(4'h2, 1'b1, 8'h1a);
    wb(4'h1, 1'b1, 8'h34);
    chk(pc_o, 13'h1a34);
    wb(4'h5, 1'b0, 8'h00);
    chk(rdat, 32'h1a34);
    wb(4'h1, 1'b1, 8'hff);
    chk(pc_o, 13'h1aff);
    wb(4'h2, 1'b1, 8'h1b);
    wb(4'h1, 1'b1, 8'h00);
    chk(pc_o, 13'h1b00);
    op(3'h2, 11'h555);
    chk(pc_o, 13'h1d55);
    wb(4'h2, 1'b1, 8'h1f);
    wb(4'h1, 1'b1, 8'hff);
    op(3'h1, 11'h000);
    chk(pc_o, 13'h0000);
    $display("test pc done");
    wb(4'h2, 1'b1, 8'h1a);
    epc = 13'h0000;
    sp = 3'h0;
    for (int i = 0; i < 10; i++) begin
      st[sp] = (i == 9) ? epc : epc + 13'h0001;
      sp++;
      epc = (i == 9) ? 13'h0004 : {2'b11, 11'h100 + 11'(i)};
      op((i == 9) ? 3'h7 : 3'h3, 11'h100 + 11'(i));
      chk(pc_o, epc);
    end
    for (int i = 0; i < 9; i++) begin
      sp--;
      epc = st[sp];
      op(3'h6, 11'h000);
      chk(pc_o, epc);
    end
    wb(4'h2, 1'b0, 8'h00);
    chk(rdat, 32'h1a);
    $display("test stack done");
    wb(4'h4, 1'b1, 8'h80);
    wb(4'h3, 1'b1, 8'h85);
    chk(data_addr_o, 9'h185);
    wb(4'h6, 1'b0, 8'h00);
    chk(rdat, 32'h3c);
    wb(4'h6, 1'b1, 8'h77);
    wb(4'h3, 1'b1, 8'h80);
    wb(4'h6, 1'b0, 8'h00);
    chk(rdat, 32'h00);
    wb(4'h6, 1'b1, 8'h77);
    chk(n_dw, 32'h1);
    chk(n_dr, 32'h1);
    $display("test indirect done");
    for (int k = 0; k < 16; k++) begin
      wb(4'h0, 1'b1, {4'h8, k[3], k[2:0]});
      repeat (300) @(posedge clk_i);
      b0 = n_tt;
      b1 = n_wt;
      repeat (256) @(posedge clk_i);
      chk(n_tt - b0, k[3] ? 256 : 256 >> (k[2:0] + 1));
      if (k[3]) chk(n_wt - b1, 128 >> k[2:0]);
    end
    for (int b = 0; b < 2; b++) begin
      wb(4'h0, 1'b1, {1'b1, b[0], 1'b1, b[0], 4'h8});
      repeat (8) @(posedge clk_i);
      b0 = n_tt;
      b1 = n_ei;
      for (int j = 0; j < 7; j++) begin
        ipin <= ~ipin;
        tpin <= ~tpin;
        repeat (8) @(posedge clk_i);
      end
      chk(n_tt - b0, b[0] ? 3 : 4);
      chk(n_ei - b1, b[0] ? 4 : 3);
      ipin <= 1'b0;
      tpin <= 1'b0;
    end
    $display("test timing controls done");
    op(3'h2, 11'h123);
    chk(pc_o, 13'h1923);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(pc_o, 13'h0000);
    $display("test reset done");
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    $display("Error at %0t: timeout", $time);
    wrap_up();
  end
endmodule
